// File: core/rtcss_fifo.sv
// Write path FIFO with a registered output stage
`default_nettype none
`include "rtcss_defines.svh"

module rtcss_fifo #(
  parameter int WIDTH = `RTCSS_WR_WIDTH,
  parameter int DEPTH = `RTCSS_FIFO_DEPTH
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;

  wire push = in_valid && in_ready;
  wire pop  = (cnt_q != '0) && (!out_valid || out_ready);

  // The output stage counts toward the depth, else one extra word slips in
  wire [AW:0] used = cnt_q + (AW+1)'(out_valid);

  assign in_ready = (used != (AW+1)'(DEPTH));

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Output word is a flop so the consumer sees no array read path
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wr_q      <= '0;
      rd_q      <= '0;
      cnt_q     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      if (push) wr_q <= wr_q + AW'(1);
      if (pop) rd_q <= rd_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      if (pop) begin
        out_valid <= 1'b1;
        out_data  <= mem[rd_q];
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end

endmodule // rtcss_fifo

`default_nettype wire

// File: core/rtcss_slave.sv
// Two-wire serial slave giving a bus master access to the register array
//
// Contract
// - Address byte after start carries the seven-bit identifier in its top bits.
// - Address byte bit zero: one selects read, zero selects write.
// - Compare identifier only after the whole byte; acknowledge on a match.
// - Register pointer is zero after reset.
// - Write is start, address, register, data, stop; all three acknowledged. The data byte is not acknowledged when the write buffer is full.
// - After a write completes the interface returns to standby.
// - Read: write address, register byte, repeated start, read address.
// - Keep sending bytes while the master acknowledges after the eighth bit.
// - Pointer loads from register byte and increments per transmitted byte.
// - Pointer wraps from the top location to zero and keeps sending.
// - Start and stop are data edges with clock high; data moves only low.
// - Transmitter releases data after eight bits; receiver pulls ninth low.
// - Bytes move most significant bit first.
// - Ignore all traffic until a start; data pin released after reset.
`default_nettype none
`include "rtcss_defines.svh"

module rtcss_slave #(
  parameter logic [6:0] DEV_ID = `RTCSS_DEV_ID  // Arbitrary value
) (
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  output var  logic                    sda_o,
  output var  logic                    sda_oe,
  output var  logic [`RTCSS_PTR_W-1:0] reg_rd_addr,
  input  wire logic [7:0]              reg_rd_data,
  output var  logic                    wr_valid,
  input  wire logic                    wr_ready,
  output var  logic [`RTCSS_PTR_W-1:0] wr_addr,
  output var  logic [7:0]              wr_data
);

  function automatic logic [`RTCSS_PTR_W-1:0] ptr_step(
    input logic [`RTCSS_PTR_W-1:0] p
  );
    return (p == `RTCSS_PTR_TOP) ? `RTCSS_PTR_RESET : p + `RTCSS_PTR_ONE;
  endfunction

  logic [1:0]                 line_s;
  logic                       scl_p_q;
  logic                       sda_p_q;
  rtcss_pkg::rtcss_state_t    state_q;
  rtcss_pkg::rtcss_state_t    state_d;
  rtcss_pkg::rtcss_state_t    nxt_q;
  rtcss_pkg::rtcss_state_t    nxt_d;
  logic [3:0]                 bitcnt_q;
  logic [3:0]                 bitcnt_d;
  logic [7:0]                 rx_q;
  logic [7:0]                 tx_q;
  logic [`RTCSS_PTR_W-1:0]    ptr_q;
  logic                       mack_q;
  logic                       sda_oe_q;
  logic                       sda_oe_d;
  logic                       fifo_in_ready;
  logic [`RTCSS_WR_WIDTH-1:0] fifo_out;

  // Both lines come from the master's domain
  rtcss_sync #(
    .WIDTH (2)
  ) u_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .d        ({scl_in, sda_in}),
    .q        (line_s)
  );

  wire scl_s = line_s[1];
  wire sda_s = line_s[0];

  // Line decoding; the edge detectors look only at synchronised copies
  wire scl_rise = scl_s && !scl_p_q;
  wire scl_fall = !scl_s && scl_p_q;
  wire start_c  = scl_s && scl_p_q && sda_p_q && !sda_s;
  wire stop_c   = scl_s && scl_p_q && !sda_p_q && sda_s;

  wire st_idle = (state_q == rtcss_pkg::ST_IDLE);
  wire st_dev  = (state_q == rtcss_pkg::ST_DEV);
  wire st_reg  = (state_q == rtcss_pkg::ST_REG);
  wire st_data = (state_q == rtcss_pkg::ST_DATA);
  wire st_ack  = (state_q == rtcss_pkg::ST_ACK);
  wire st_send = (state_q == rtcss_pkg::ST_SEND);
  wire st_ignr = (state_q == rtcss_pkg::ST_IGNR);

  wire receiving = st_dev || st_reg || st_data;
  wire active    = !(st_idle || st_ignr);
  wire bit_in    = scl_rise && receiving && (bitcnt_q < `RTCSS_BYTE_BITS);
  wire byte_done = scl_fall && receiving && (bitcnt_q == `RTCSS_BYTE_BITS);
  wire slot_end  = scl_fall && (st_ack || st_send)
                   && (bitcnt_q == `RTCSS_ACK_BIT);
  wire id_match  = (rx_q[7:1] == DEV_ID);
  wire push      = byte_done && st_data && fifo_in_ready;
  wire ack_ok    = (st_dev && id_match) || st_reg || push;
  wire tx_load   = slot_end && ((st_ack && nxt_q == rtcss_pkg::ST_SEND)
                   || (st_send && mack_q));
  wire tx_shift  = scl_fall && st_send && (bitcnt_q != `RTCSS_BIT_ZERO)
                   && (bitcnt_q < `RTCSS_BYTE_BITS);
  wire tx_done   = scl_fall && st_send && (bitcnt_q == `RTCSS_BYTE_BITS);
  wire mack_smp  = scl_rise && st_send && (bitcnt_q == `RTCSS_BYTE_BITS);

  always_comb begin
    state_d = state_q;
    nxt_d   = nxt_q;
    if (stop_c) begin
      state_d = rtcss_pkg::ST_IDLE;
    end else if (start_c) begin
      state_d = rtcss_pkg::ST_DEV;
    end else begin
      unique case (state_q)
        rtcss_pkg::ST_DEV: begin
          if (byte_done && id_match) begin
            state_d = rtcss_pkg::ST_ACK;
            nxt_d   = rx_q[0] ? rtcss_pkg::ST_SEND : rtcss_pkg::ST_REG;
          end else if (byte_done) begin
            state_d = rtcss_pkg::ST_IGNR;
          end
        end
        rtcss_pkg::ST_REG: begin
          if (byte_done) begin
            state_d = rtcss_pkg::ST_ACK;
            nxt_d   = rtcss_pkg::ST_DATA;
          end
        end
        rtcss_pkg::ST_DATA: begin
          // A full buffer refuses the byte with a no-acknowledge
          if (byte_done) begin
            state_d = push ? rtcss_pkg::ST_ACK : rtcss_pkg::ST_IGNR;
            nxt_d   = rtcss_pkg::ST_IGNR;
          end
        end
        rtcss_pkg::ST_ACK: begin
          if (slot_end) state_d = nxt_q;
        end
        rtcss_pkg::ST_SEND: begin
          if (slot_end && !mack_q) state_d = rtcss_pkg::ST_IGNR;
        end
        rtcss_pkg::ST_IDLE, rtcss_pkg::ST_IGNR: begin
          state_d = state_q;
        end
        default: begin
          state_d = rtcss_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign bitcnt_d = (start_c || stop_c || slot_end) ? `RTCSS_BIT_ZERO :
                    (scl_rise && active && bitcnt_q < `RTCSS_ACK_BIT)
                    ? bitcnt_q + 4'h1 : bitcnt_q;

  // Data pin only moves after a falling clock edge
  always_comb begin
    sda_oe_d = sda_oe_q;
    if (start_c || stop_c) begin
      sda_oe_d = 1'b0;
    end else if (byte_done) begin
      sda_oe_d = ack_ok;
    end else if (slot_end) begin
      sda_oe_d = tx_load && !reg_rd_data[7];
    end else if (tx_shift) begin
      sda_oe_d = !tx_q[6];
    end else if (tx_done) begin
      sda_oe_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_q  <= rtcss_pkg::ST_IDLE;
      nxt_q    <= rtcss_pkg::ST_IDLE;
      bitcnt_q <= `RTCSS_BIT_ZERO;
      sda_oe_q <= 1'b0;
      mack_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      nxt_q    <= nxt_d;
      bitcnt_q <= bitcnt_d;
      sda_oe_q <= sda_oe_d;
      if (mack_smp) mack_q <= !sda_s;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rx_q <= 8'h00;
      tx_q <= 8'h00;
    end else begin
      if (bit_in) rx_q <= {rx_q[6:0], sda_s};
      if (tx_load) begin
        tx_q <= reg_rd_data;
      end else if (tx_shift) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // Pointer survives stop so a later current-address read continues
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ptr_q <= `RTCSS_PTR_RESET;
    end else if (byte_done && st_reg) begin
      ptr_q <= rx_q[`RTCSS_PTR_W-1:0];
    end else if (tx_load) begin
      ptr_q <= ptr_step(ptr_q);
    end
  end

  // Open drain: the driven level is always low
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  assign sda_oe      = sda_oe_q;
  assign reg_rd_addr = ptr_q;

  // Buffer decouples bus timing from the array's write acceptance
  rtcss_fifo #(
    .WIDTH (`RTCSS_WR_WIDTH),
    .DEPTH (`RTCSS_FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   ({ptr_q, rx_q}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (fifo_out)
  );

  assign wr_addr = fifo_out[`RTCSS_WR_WIDTH-1:8];
  assign wr_data = fifo_out[7:0];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  a_idle_released: assert property (
    st_idle |-> !sda_oe)
    else $error("data pin driven while idle");

  a_match_acks: assert property (
    byte_done && st_dev && id_match |=> st_ack && sda_oe)
    else $error("matching identifier not acknowledged");

  a_mismatch_quiet: assert property (
    byte_done && st_dev && !id_match |=> st_ignr && !sda_oe)
    else $error("mismatched identifier not ignored");

  a_dir_select: assert property (
    byte_done && st_dev && id_match |=>
      nxt_q == ($past(rx_q[0]) ? rtcss_pkg::ST_SEND : rtcss_pkg::ST_REG))
    else $error("direction bit misread");

  a_ptr_load: assert property (
    byte_done && st_reg |=> reg_rd_addr == $past(rx_q[4:0]))
    else $error("pointer not loaded from register byte");

  a_ptr_wrap: assert property (
    tx_load && reg_rd_addr == `RTCSS_PTR_TOP |=>
      reg_rd_addr == `RTCSS_PTR_RESET)
    else $error("pointer did not wrap to zero");

  a_ptr_step: assert property (
    tx_load |=> reg_rd_addr == ptr_step($past(reg_rd_addr)))
    else $error("pointer not advanced per byte");

  a_write_standby: assert property (
    push |=> st_ack ##0 nxt_q == rtcss_pkg::ST_IGNR)
    else $error("write did not head to standby");

  a_nack_release: assert property (
    slot_end && st_send && !mack_q |=> st_ignr && !sda_oe)
    else $error("data pin held after no-acknowledge");

  a_first_bit: assert property (
    tx_load |=> sda_oe == !$past(reg_rd_data[7]))
    else $error("first transmitted bit is not the msb");

  a_start_restart: assert property (
    start_c && !stop_c |=> st_dev && bitcnt_q == `RTCSS_BIT_ZERO)
    else $error("start did not restart the frame");

  a_oe_clock_low: assert property (
    $changed(sda_oe) |-> !$past(scl_s))
    else $error("data pin changed while clock high");

  a_release_slot: assert property (
    tx_done |=> !sda_oe [*2])
    else $error("transmitter kept data pin after eighth bit");

  c_write_done: cover property (push ##[1:1000] stop_c);
  c_read_two: cover property (tx_load ##[1:1000] tx_load);
  c_id_mismatch: cover property (byte_done && st_dev && !id_match);
  c_ptr_wrap: cover property (tx_load && reg_rd_addr == `RTCSS_PTR_TOP);

endmodule // rtcss_slave

`default_nettype wire

// File: core/rtcss_sync.sv
// Two-flop synchroniser for the bus lines
`default_nettype none
`include "rtcss_defines.svh"

module rtcss_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // Reset to the released bus level so no edge is seen at release
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      meta_q <= WIDTH'(`RTCSS_BUS_IDLE);
      q      <= WIDTH'(`RTCSS_BUS_IDLE);
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // rtcss_sync

`default_nettype wire

// File: include/rtcss_defines.svh
// Constants of the serial slave that opens the clock's register array
`ifndef RTCSS_DEFINES_SVH
`define RTCSS_DEFINES_SVH

// Bit counter values inside one byte frame
`define RTCSS_BIT_ZERO   4'h0
`define RTCSS_BYTE_BITS  4'h8
`define RTCSS_ACK_BIT    4'h9

// Register pointer: five bits, top location and power-up value
`define RTCSS_PTR_W      5
`define RTCSS_PTR_TOP    5'h1F
`define RTCSS_PTR_RESET  5'h00
`define RTCSS_PTR_ONE    5'h01

// Identifier of the slave; the value is arbitrary
`define RTCSS_DEV_ID     7'h2A

// Write path buffer: pointer plus data byte, eight entries
`define RTCSS_WR_WIDTH   13
`define RTCSS_FIFO_DEPTH 8

// Level of both bus lines while the bus rests
`define RTCSS_BUS_IDLE   2'h3

`endif

// File: include/rtcss_pkg.sv
// Types shared by the serial slave
`default_nettype none

package rtcss_pkg;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_DEV  = 7'h02,
    ST_REG  = 7'h04,
    ST_DATA = 7'h08,
    ST_ACK  = 7'h10,
    ST_SEND = 7'h20,
    ST_IGNR = 7'h40
  } rtcss_state_t;

endpackage

`default_nettype wire

// File: tb/rtcss_mst_model.sv
// Two-wire bus master model: drives the serial clock, pulls data low
`default_nettype none

module rtcss_mst_model (
  input  wire logic core_clk,
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Quarter of a bit; every change lands on a falling core edge
  task automatic qtr();
    repeat (4) @(negedge core_clk);
  endtask

  // Serves from idle and, with the clock low, as a repeated start
  task automatic start();
    sda_pull = 1'b0;
    qtr();
    scl = 1'b1;
    qtr();
    sda_pull = 1'b1;
    qtr();
    scl = 1'b0;
    qtr();
  endtask

  task automatic stop();
    sda_pull = 1'b1;
    qtr();
    scl = 1'b1;
    qtr();
    sda_pull = 1'b0;
    qtr();
  endtask

  // Data moves only while the clock is low; sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    sda_pull = ~b;
    qtr();
    scl = 1'b1;
    qtr();
    r = sda_line;
    qtr();
    scl = 1'b0;
    qtr();
  endtask

  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic get_byte(input logic ack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, v[i]);
    end
    bit_io(~ack, r);
  endtask
endmodule // rtcss_mst_model

`default_nettype wire

// File: tb/rtcss_slave_tb_top.sv
// Self-checking bench of the serial slave with master model and array
`default_nettype none
`include "rtcss_defines.svh"

`define CHK(a, e) \
  begin \
    total_checks++; \
    if ((a) !== (e)) begin \
      n_fail++; \
      $display("[ERR] %0t got %h want %h", $time, (a), (e)); \
    end \
  end

module rtcss_slave_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [6:0] ID = 7'h2A;  // Arbitrary identifier
  localparam int LIMIT = 60000;
  localparam logic [15:0] ROWS [6] = '{16'h0012, 16'h0534, 16'h1F56,
                                       16'hE778, 16'h0A9A, 16'h00BC};

  logic                    core_clk = 1'b0;
  logic                    resetn = 1'b0;
  logic                    scl;
  logic                    m_pull;
  logic                    sda_o;
  logic                    sda_oe;
  logic                    sda_line;
  logic [`RTCSS_PTR_W-1:0] rd_addr;
  logic [7:0]              rd_data;
  logic                    wr_valid;
  logic                    wr_ready = 1'b1;
  logic [`RTCSS_PTR_W-1:0] wr_addr;
  logic [7:0]              wr_data;
  logic [7:0]              mem [32];
  logic [7:0]              model [32];
  int                      n_fail = 0;
  int                      total_checks = 0;
  int                      cycles = 0;
  logic                    a0, a1, a2, a3;
  logic [7:0]              d;

  // Open-drain data wire with pull-up
  assign sda_line = ~(m_pull | (sda_oe & ~sda_o));
  assign rd_data = mem[rd_addr];

  always #4 core_clk = ~core_clk;

  rtcss_slave #(.DEV_ID(ID)) i_dut (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .scl_in      (scl),
    .sda_in      (sda_line),
    .sda_o       (sda_o),
    .sda_oe      (sda_oe),
    .reg_rd_addr (rd_addr),
    .reg_rd_data (rd_data),
    .wr_valid    (wr_valid),
    .wr_ready    (wr_ready),
    .wr_addr     (wr_addr),
    .wr_data     (wr_data)
  );

  rtcss_mst_model i_mst (
    .core_clk (core_clk),
    .sda_line (sda_line),
    .scl      (scl),
    .sda_pull (m_pull)
  );

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (wr_valid && wr_ready) begin
      mem[wr_addr] <= wr_data;
    end
    if (cycles == LIMIT) begin
      $display("[ERR] %0t run exceeded its cycle ceiling", $time);
      n_fail++;
      wrap_up();
    end
  end

  task automatic wr_txn(input logic [7:0] r, input logic [7:0] v);
    i_mst.start();
    i_mst.put_byte({ID, 1'b0}, a0);
    i_mst.put_byte(r, a1);
    i_mst.put_byte(v, a2);
    i_mst.stop();
  endtask

  // Same identifier in both halves of the random read
  task automatic rd_txn(input logic [7:0] r, input int n);
    i_mst.start();
    i_mst.put_byte({ID, 1'b0}, a0);
    i_mst.put_byte(r, a1);
    i_mst.start();
    i_mst.put_byte({ID, 1'b1}, a2);
    `CHK({a0, a1, a2}, 3'b111)
    for (int i = 0; i < n; i++) begin
      i_mst.get_byte(i < n - 1, d);
      `CHK(d, model[(r[4:0] + i) % 32])
    end
    i_mst.stop();
  endtask

  task automatic cur_rd(input logic [4:0] p);
    i_mst.start();
    i_mst.put_byte({ID, 1'b1}, a0);
    i_mst.get_byte(1'b0, d);
    i_mst.stop();
    `CHK({a0, d}, {1'b1, model[p]})
  endtask

  initial begin
    for (int i = 0; i < 32; i++) begin
      mem[i] = 8'(i * 8'h25 + 8'h05);
      model[i] = 8'(i * 8'h25 + 8'h05);
    end
    repeat (20) @(negedge core_clk);
    `CHK({sda_oe, rd_addr, wr_valid}, 7'h00)
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    cur_rd(5'h00);
    $display("reset test done");
    foreach (ROWS[k]) begin
      wr_txn(ROWS[k][15:8], ROWS[k][7:0]);
      `CHK({a0, a1, a2}, 3'b111)
      model[ROWS[k][12:8]] = ROWS[k][7:0];
      rd_txn(ROWS[k][15:8], 1);
    end
    $display("row test done");
    i_mst.start();
    i_mst.put_byte({ID ^ 7'h01, 1'b0}, a0);
    i_mst.put_byte(8'h03, a1);
    i_mst.put_byte(8'h99, a2);
    i_mst.stop();
    `CHK({a0, a1, a2, wr_valid}, 4'h0)
    i_mst.start();
    i_mst.put_byte({ID, 1'b0}, a0);
    i_mst.put_byte(8'h04, a1);
    i_mst.put_byte(8'h44, a2);
    i_mst.put_byte(8'h55, a3);
    i_mst.stop();
    `CHK({a0, a1, a2, a3}, 4'hE)
    model[4] = 8'h44;
    rd_txn(8'h03, 2);
    $display("refusal test done");
    rd_txn(8'h1E, 4);
    cur_rd(5'h02);
    $display("wrap test done");
    // Array stalls; the buffer must refuse the ninth data byte
    wr_ready = 1'b0;
    for (int i = 0; i < 9; i++) begin
      wr_txn(8'h08 + 8'(i), 8'hC0 + 8'(i));
      `CHK(a2, i < 8)
      if (i < 8) begin
        model[8 + i] = 8'hC0 + 8'(i);
      end
    end
    `CHK(wr_valid, 1'b1)
    wr_ready = 1'b1;
    repeat (40) @(negedge core_clk);
    rd_txn(8'h08, 9);
    $display("buffer test done");
    wrap_up();
  end
endmodule // rtcss_slave_tb_top

`default_nettype wire
